// ==== digipot_pkg.sv ====
// constants, types and command codes for the digipot serial control
// assumes one system clock; serial pins arrive asynchronous to it
package digipot_pkg;

    ////////////////////////////////////////////////////////////////////
    // sizes
    localparam int TAP_W = 8;        // tap field width
    localparam int SLOT_W = 9;       // buffer enable bit plus tap
    localparam int SLOT_COUNT = 4;   // nonvolatile slots
    localparam int SLOT_IDX_W = 2;   // slot index width
    localparam int FRAME_BITS = 24;  // bits per command frame
    localparam int BIT_CNT_W = 5;    // frame bit counter width
    localparam int PIN_COUNT = 4;    // synchronised serial pins

    ////////////////////////////////////////////////////////////////////
    // reset values and limits
    localparam logic [SLOT_W-1:0] TAP_RESET = 9'h000;  // before recall
    localparam logic [SLOT_W-1:0] SLOT_RESET = 9'h080; // mid-scale
    localparam logic [TAP_W-1:0] TAP_MAX = 8'hFF;      // top tap
    localparam logic [TAP_W-1:0] TAP_MIN = 8'h00;      // bottom tap
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h17; // bit 23
    // pin idle levels {cs_n, sclk, sdi, wp_n}
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 4'h9;

    ////////////////////////////////////////////////////////////////////
    // timing
    localparam int SYS_CLK_HZ = 20_000_000;  // system clock rate
    localparam int NV_WRITE_TIME_US = 5000;  // slot programming time
    // longest-time figure, rounded down, at least one cycle
    localparam int NV_WRITE_CYCLES =
        (NV_WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000) < 1) ? 1 :
        NV_WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000);

    ////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [3:0] CMD_NOP = 4'h0;       // no operation
    localparam logic [3:0] CMD_WRITE_TAP = 4'h1; // load tap from data
    localparam logic [3:0] CMD_READ_TAP = 4'h2;  // return tap
    localparam logic [3:0] CMD_TAP_UP = 4'h3;    // step up
    localparam logic [3:0] CMD_READ_SLOT = 4'h4; // return slot
    localparam logic [3:0] CMD_PROG_SLOT = 4'h5; // write data to slot
    localparam logic [3:0] CMD_LOAD_TAP = 4'h6;  // slot into tap
    localparam logic [3:0] CMD_SAVE_TAP = 4'h7;  // tap into slot
    localparam logic [3:0] CMD_TAP_DOWN = 4'h8;  // step down

    ////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic [3:0] cmd;           // command field
        logic slot_select_hi;      // slot index msb
        logic slot_select_lo;      // slot index lsb
        logic [1:0] channel;       // always zero on this part
        logic [6:0] unused;        // don't care
        logic [SLOT_W-1:0] data;   // buffer_enable_bit and tap
    } frame_t;

    typedef struct packed {
        logic cs_n;                // chip select, low active
        logic sclk;                // serial clock
        logic sdi;                 // serial data in
        logic wp_n;                // write protect, low active
    } pins_t;

    typedef enum logic [1:0] {
        ST_RECALL,                 // power-up copy of slot zero
        ST_WAIT_SELECT,            // waiting for first select edge
        ST_RUN                     // normal command handling
    } ctrl_state_t;

endpackage : digipot_pkg

// ==== nv_slot_store.sv ====
// four nonvolatile slots with a timed programming cycle
// assumes one write request at a time; requests while busy dropped
module nv_slot_store
    import digipot_pkg::*;
#(
    parameter int WRITE_CYCLES = NV_WRITE_CYCLES  // programming time
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // write request
    input wire logic i_wr_en,
    input wire logic [SLOT_IDX_W-1:0] i_wr_idx,
    input wire logic [SLOT_W-1:0] i_wr_data,
    // read port
    input wire logic [SLOT_IDX_W-1:0] i_rd_idx,
    output logic [SLOT_W-1:0] o_rd_data,
    // status
    output logic o_busy
);

    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);

    logic [SLOT_W-1:0] slot_q [SLOT_COUNT];  // slot contents
    logic [CNT_W-1:0] cnt_q;                 // cycle counter
    logic busy_q;                            // programming underway
    logic [SLOT_IDX_W-1:0] idx_q;            // target slot
    logic [SLOT_W-1:0] data_q;               // value to commit

    ////////////////////////////////////////////////////////////////////
    // programming cycle timer; value commits at the end so a
    // reader never sees a half-finished slot
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            idx_q <= '0;
            data_q <= '0;
        end else if (busy_q) begin
            if (cnt_q == CNT_LAST) begin
                busy_q <= 1'b0;  // cycle done
            end
            cnt_q <= cnt_q + CNT_W'(1);
        end else if (i_wr_en) begin
            busy_q <= 1'b1;  // start cycle
            cnt_q <= '0;
            idx_q <= i_wr_idx;
            data_q <= i_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // slot array; reset stands in for factory contents
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < SLOT_COUNT; i++) begin
                slot_q[i] <= SLOT_RESET;
            end
        end else if (busy_q && cnt_q == CNT_LAST) begin
            slot_q[idx_q] <= data_q;
        end
    end

    // recall port, always permitted
    assign o_rd_data = slot_q[i_rd_idx];
    assign o_busy = busy_q;

endmodule : nv_slot_store

// ==== digipot_serial_control.sv ====
// serial control logic of a 256-step digital potentiometer
// assumes serial pins are asynchronous and much slower than i_sys_clk
module digipot_serial_control
    import digipot_pkg::*;
#(
    parameter int NV_WRITE_CYC = NV_WRITE_CYCLES  // slot write time
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // serial pins from host
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_wp_n,
    // open-drain serial output
    output logic o_sdo,
    output logic o_sdo_oe,
    // wiper setting to the resistor array
    output logic [TAP_W-1:0] o_tap,
    output logic o_buffer_enable,
    // power and status
    output logic o_nv_busy,
    output logic o_standby
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    pins_t pins_raw;                      // raw pin bundle
    logic [PIN_COUNT-1:0] sync1_q;        // first stage, not looked at
    logic [PIN_COUNT-1:0] sync2_q;        // second stage
    logic [PIN_COUNT-1:0] sync3_q;        // delayed copy for edges
    pins_t pin;                           // clean current levels
    pins_t pin_d1;                        // clean previous levels

    assign pins_raw = '{cs_n: i_cs_n, sclk: i_sclk, sdi: i_sdi,
                        wp_n: i_wp_n};

    // one three-flop chain per pin: two to synchronise, one delayed copy for edges
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_sync
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sync1_q[g] <= PIN_IDLE[g];
                    sync2_q[g] <= PIN_IDLE[g];
                    sync3_q[g] <= PIN_IDLE[g];
                end else begin
                    sync1_q[g] <= pins_raw[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                end
            end
        end
    endgenerate

    assign pin = pins_t'(sync2_q);
    assign pin_d1 = pins_t'(sync3_q);

    // edges since reset until the chain holds real pin levels; the
    // reset value of the chain would fake a select edge if cs is low
    logic [1:0] settle_q;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            settle_q <= 2'h0;
        end else if (settle_q != 2'h3) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin events
    logic cs_fall;   // select begins
    logic cs_rise;   // frame ends
    logic sclk_rise; // sample point
    logic sclk_fall; // output change point
    logic selected;  // chip select held low

    assign selected = ~pin.cs_n;
    assign cs_fall = pin_d1.cs_n & ~pin.cs_n;
    assign cs_rise = ~pin_d1.cs_n & pin.cs_n;
    assign sclk_rise = selected & ~pin_d1.sclk & pin.sclk;
    assign sclk_fall = selected & pin_d1.sclk & ~pin.sclk;

    ////////////////////////////////////////////////////////////////////
    // decode helper used by recall, read-back and store paths
    function automatic logic [SLOT_IDX_W-1:0] slot_of(input frame_t f);
        slot_of = {f.slot_select_hi, f.slot_select_lo};
    endfunction : slot_of

    ////////////////////////////////////////////////////////////////////
    // control state
    ctrl_state_t state_q;             // power-up sequence
    logic [SLOT_W-1:0] tap_q;         // buffer enable and tap
    frame_t shift_q;                  // frame shift register
    logic [BIT_CNT_W-1:0] bit_cnt_q;  // bits in current word
    logic whole_q;                    // at least one whole word in
    logic sdo_q;                      // bit being presented
    logic frame_go;                   // act on the frame now
    logic nv_busy;                    // slot programming underway
    logic nv_wr_en;                   // start slot programming
    logic [SLOT_W-1:0] nv_wr_data;    // value for the slot
    logic [SLOT_IDX_W-1:0] rd_idx;    // slot being recalled
    logic [SLOT_W-1:0] rd_data;       // recalled slot value
    logic [SLOT_W-1:0] read_value;    // value a read returns
    logic is_read;                    // frame is a read command

    ////////////////////////////////////////////////////////////////////
    // power-up sequence: recall slot zero, then wait for the
    // first select edge so a floating bus at power-up is ignored
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_RECALL;
        end else begin
            case (state_q)
                ST_RECALL: begin
                    // recall repeats until the pin history is real
                    if (settle_q == 2'h3) begin
                        state_q <= ST_WAIT_SELECT;
                    end
                end
                ST_WAIT_SELECT: begin
                    if (cs_fall) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_q <= ST_RUN;  // stays until reset
                end
                default: begin
                    state_q <= ST_RECALL;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bit counter; a frame is good when a whole number of
    // words came in, so a daisy chain of n parts also works
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_cnt_q <= '0;
            whole_q <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_q <= '0;  // new frame
            whole_q <= 1'b0;
        end else if (sclk_rise) begin
            if (bit_cnt_q == LAST_BIT) begin
                bit_cnt_q <= '0;
                whole_q <= 1'b1;
            end else begin
                bit_cnt_q <= bit_cnt_q + BIT_CNT_W'(1);
            end
        end
    end

    // commands are refused while a slot write runs
    assign frame_go = (state_q == ST_RUN) & cs_rise & whole_q &
                      (bit_cnt_q == '0) & ~nv_busy;

    ////////////////////////////////////////////////////////////////////
    // read-back selection
    assign rd_idx = (state_q == ST_RECALL) ? '0 : slot_of(shift_q);
    assign is_read = (shift_q.cmd == CMD_READ_TAP) |
                     (shift_q.cmd == CMD_READ_SLOT);
    assign read_value = (shift_q.cmd == CMD_READ_TAP) ? tap_q : rd_data;

    ////////////////////////////////////////////////////////////////////
    // frame shift register; msb leaves first and the word that
    // was in before is pushed out behind, feeding the next part
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_q <= '0;
        end else if (state_q != ST_RUN) begin
            shift_q <= '0;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], pin.sdi};
        end else if (frame_go && is_read) begin
            shift_q.data <= read_value;  // reply rides next frame
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output bit: first at select fall, the rest on clock falls
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sdo_q <= 1'b1;
        end else if (cs_fall) begin
            sdo_q <= shift_q[FRAME_BITS-1];
        end else if (sclk_fall) begin
            sdo_q <= shift_q[FRAME_BITS-1];
        end else if (!selected) begin
            sdo_q <= 1'b1;  // released
        end
    end

    // open drain: only ever pulls low, never while deselected
    assign o_sdo = 1'b0;
    assign o_sdo_oe = selected & (state_q == ST_RUN) & ~sdo_q;

    ////////////////////////////////////////////////////////////////////
    // tap setting register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tap_q <= TAP_RESET;
        end else if (state_q == ST_RECALL) begin
            tap_q <= rd_data;
        end else if (frame_go) begin
            case (shift_q.cmd)
                CMD_WRITE_TAP: begin
                    // buffer enable only changes through a slot
                    tap_q[TAP_W-1:0] <= shift_q.data[TAP_W-1:0];
                end
                CMD_LOAD_TAP: begin
                    tap_q <= rd_data;
                end
                CMD_TAP_UP: begin
                    if (tap_q[TAP_W-1:0] != TAP_MAX) begin
                        tap_q[TAP_W-1:0] <= tap_q[TAP_W-1:0] +
                                            TAP_W'(1);
                    end
                end
                CMD_TAP_DOWN: begin
                    if (tap_q[TAP_W-1:0] != TAP_MIN) begin
                        tap_q[TAP_W-1:0] <= tap_q[TAP_W-1:0] -
                                            TAP_W'(1);
                    end
                end
                default: begin
                    tap_q <= tap_q;
                end
            endcase
        end
    end

    assign o_tap = tap_q[TAP_W-1:0];
    assign o_buffer_enable = tap_q[SLOT_W-1];

    ////////////////////////////////////////////////////////////////////
    // slot programming requests; write protect stops both kinds
    assign nv_wr_en = frame_go & pin.wp_n &
                      ((shift_q.cmd == CMD_PROG_SLOT) |
                       (shift_q.cmd == CMD_SAVE_TAP));
    assign nv_wr_data = (shift_q.cmd == CMD_SAVE_TAP) ? tap_q :
                        shift_q.data;

    nv_slot_store #(
        .WRITE_CYCLES(NV_WRITE_CYC)
    ) u_slots (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_wr_en(nv_wr_en),
        .i_wr_idx(slot_of(shift_q)),
        .i_wr_data(nv_wr_data),
        .i_rd_idx(rd_idx),
        .o_rd_data(rd_data),
        .o_busy(nv_busy)
    );

    ////////////////////////////////////////////////////////////////////
    // power mode: a running slot write keeps the part awake
    assign o_nv_busy = nv_busy;
    assign o_standby = pin.cs_n & ~nv_busy;

endmodule : digipot_serial_control

// ==== digipot_serial_control_monitor.sv ====
// assertion checker on the digipot serial control ports
// assumes each serial pin level lasts four or more clocks
module digipot_serial_control_monitor
    import digipot_pkg::*;
#(
    parameter int NV_WRITE_CYC = NV_WRITE_CYCLES  // store time
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // serial pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_wp_n,
    // device outputs
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic [TAP_W-1:0] o_tap,
    input wire logic o_buffer_enable,
    input wire logic o_nv_busy,
    input wire logic o_standby
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////
    logic [3:0] hi_cnt_q; // samples with cs high, saturating
    logic [2:0] age_q; // edges since reset, saturating
    logic [19:0] busy_cnt_q; // samples with busy high

    // cs high age: places tap and busy changes after a frame end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) hi_cnt_q <= 4'h0;
        else if (!i_cs_n) hi_cnt_q <= 4'h0;
        else if (hi_cnt_q != 4'hF) hi_cnt_q <= hi_cnt_q + 4'h1;
    end

    // reset age: hides the power-up recall from the frame checks
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) age_q <= 3'h0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end

    // store length counter, cleared whenever busy is low
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) busy_cnt_q <= 20'h00000;
        else if (!o_nv_busy) busy_cnt_q <= 20'h00000;
        else busy_cnt_q <= busy_cnt_q + 20'h00001;
    end

    ////////////////////////////////////////////////////////////////////
    a_sdo_released: assert property (i_cs_n [*4] |-> !o_sdo_oe)
        else $error("sdo pulled while deselected");
    a_select_active: assert property (!i_cs_n [*4] |-> !o_standby)
        else $error("standby while selected");
    a_deselect_standby: assert property
        ((i_cs_n && !o_nv_busy) [*4] |-> o_standby)
        else $error("no standby while deselected and idle");
    a_busy_awake: assert property (o_nv_busy |-> !o_standby)
        else $error("standby during a store");
    a_store_length: assert property
        ($fell(o_nv_busy) |-> busy_cnt_q == 20'(NV_WRITE_CYC))
        else $error("store time wrong");
    a_store_unprotected: assert property
        ($rose(o_nv_busy) |-> $past(i_wp_n, 4))
        else $error("store started while protected");
    a_act_at_end: assert property
        (($changed(o_tap) && age_q == 3'h7) || $rose(o_nv_busy)
        |-> hi_cnt_q inside {[2:6]})
        else $error("frame acted on away from cs rise");
    a_tap_holds_busy: assert property
        (o_nv_busy && $past(o_nv_busy) |-> $stable(o_tap))
        else $error("tap moved during a store");
    a_sdo_steady_high: assert property
        ((i_sclk && !i_cs_n) [*4] |-> $stable(o_sdo_oe))
        else $error("sdo changed while sclk high");
    a_open_drain: assert property (o_sdo_oe |-> !o_sdo)
        else $error("sdo drives high");

    c_store: cover property ($rose(o_nv_busy));
    c_read_zero: cover property (o_sdo_oe);
    c_tap_frame: cover property ($changed(o_tap) && age_q == 3'h7);

endmodule : digipot_serial_control_monitor

bind digipot_serial_control digipot_serial_control_monitor #(
    .NV_WRITE_CYC(NV_WRITE_CYC)
) u_monitor (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
    .i_sclk(i_sclk), .i_sdi(i_sdi), .i_wp_n(i_wp_n), .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe), .o_tap(o_tap),
    .o_buffer_enable(o_buffer_enable), .o_nv_busy(o_nv_busy),
    .o_standby(o_standby)
);

// ==== spi_host_model.sv ====
// host model: serial bus master for the digipot control
// assumes sdo line is pulled up; pins move on falling clock
module spi_host_model (
    // pacing clock
    input wire logic i_sys_clk,
    // pulled-up sdo line
    input wire logic i_sdo_line,
    // pins to the device
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_sdi,
    output logic o_wp_n
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle pins at time zero
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
        o_wp_n = 1'b1;
    end

    // wait n falling clock edges
    task automatic idle(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : idle

    // cs low with no edge, to be held across a reset
    task automatic hold_select();
        o_cs_n = 1'b0;
    endtask : hold_select

    // write protect level
    task automatic set_wp(input logic v);
        o_wp_n = v;
    endtask : set_wp

    // one frame msb first; hold is clocks per sclk level
    task automatic xfer(input logic [23:0] w, input int hold,
                        output logic [23:0] rx);
        idle(1);
        o_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            o_sdi = w[i];
            idle(hold);
            rx[i] = i_sdo_line;
            o_sclk = 1'b1;
            idle(hold);
            o_sclk = 1'b0;
        end
        idle(hold);
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi; // released line does not keep its value
        idle(hold + 6);
    endtask : xfer

endmodule : spi_host_model

// ==== digipot_serial_control_tb_top.sv ====
// self-checking bench for the digipot serial control
// assumes the host model paces frames; sdo has a pull-up
module digipot_serial_control_tb_top
    import digipot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int NVC = 300; // shortened store time
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, sclk, sdi, wp_n, sdo, sdo_oe, buf_en, busy, standby;
    logic [TAP_W-1:0] tap;
    logic [23:0] rx; // bits seen on sdo during a frame
    wire sdo_line = sdo_oe ? sdo : 1'b1; // board pull-up
    int err_count = 0;
    int checks_done = 0;

    always #25 clk = ~clk;

    spi_host_model host (.i_sys_clk(clk), .i_sdo_line(sdo_line),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi), .o_wp_n(wp_n));
    digipot_serial_control #(.NV_WRITE_CYC(NVC)) dut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_sdi(sdi), .i_wp_n(wp_n), .o_sdo(sdo),
        .o_sdo_oe(sdo_oe), .o_tap(tap), .o_buffer_enable(buf_en),
        .o_nv_busy(busy), .o_standby(standby));

    ////////////////////////////////////////////////////////////////////
    function automatic frame_t word(input logic [3:0] c,
                                    input logic [1:0] s,
                                    input logic [8:0] d);
        return '{c, s[1], s[0], 2'h0, 7'h00, d};
    endfunction : word

    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // one frame at the fast pace
    task automatic cmd(input logic [3:0] c, input logic [1:0] s,
                       input logic [8:0] d);
        host.xfer(word(c, s, d), 4, rx);
    endtask : cmd

    // bounded wait for a store to finish
    task automatic wait_idle();
        for (int n = 0; busy !== 1'b0; n++) begin
            if (n == 1000) begin
                $display("unexpected busy: expected 0 seen %b", busy);
                err_count++;
                summarize();
            end
            @(negedge clk);
        end
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        check("reset tap", 24'h0, tap);
        check("reset standby,oe", 24'h2, {standby, sdo_oe});
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check("recalled slot 0", 24'h080, {buf_en, tap});
    endtask : t_reset

    // cs low across reset: no falling edge, frame ignored
    task automatic t_no_select();
        host.hold_select();
        t_reset();
        cmd(CMD_WRITE_TAP, 2'h0, 9'h033);
        check("tap before select", 24'h080, {buf_en, tap});
    endtask : t_no_select

    task automatic t_write();
        cmd(CMD_WRITE_TAP, 2'h0, 9'h155);
        check("written tap", 24'h055, {buf_en, tap});
        cmd(CMD_WRITE_TAP, 2'h0, 9'h0FF);
        check("top tap", 24'h0FF, {buf_en, tap});
        check("idle sdo", 24'h1, sdo_line);
    endtask : t_write

    task automatic t_step();
        cmd(CMD_TAP_UP, 2'h0, 9'h000);
        check("up at top", 24'hFF, tap);
        cmd(CMD_TAP_DOWN, 2'h0, 9'h000);
        check("down", 24'hFE, tap);
        cmd(CMD_WRITE_TAP, 2'h0, 9'h000);
        cmd(CMD_TAP_DOWN, 2'h0, 9'h000);
        check("down at bottom", 24'h00, tap);
        cmd(CMD_TAP_UP, 2'h0, 9'h000);
        check("up", 24'h01, tap);
    endtask : t_step

    // save to every slot, a frame refused while busy, reload all
    task automatic t_store();
        for (int n = 0; n < 4; n++) begin
            cmd(CMD_WRITE_TAP, 2'h0, 9'h010 + 9'(n));
            cmd(CMD_SAVE_TAP, 2'(n), 9'h000);
            check("busy,standby", 24'h2, {busy, standby});
            if (n == 3) begin
                cmd(CMD_WRITE_TAP, 2'h0, 9'h077);
                check("tap while busy", 24'h13, tap);
            end
            wait_idle();
        end
        for (int n = 0; n < 4; n++) begin
            cmd(CMD_LOAD_TAP, 2'(n), 9'h000);
            check("loaded", 24'h10 + 24'(n), tap);
        end
    endtask : t_store

    task automatic t_protect();
        host.set_wp(1'b0);
        cmd(CMD_WRITE_TAP, 2'h0, 9'h044);
        cmd(CMD_SAVE_TAP, 2'h2, 9'h000);
        check("busy after save", 24'h0, busy);
        cmd(CMD_PROG_SLOT, 2'h2, 9'h1EE);
        check("busy after program", 24'h0, busy);
        cmd(CMD_LOAD_TAP, 2'h2, 9'h000);
        check("recall protected", 24'h012, {buf_en, tap});
        host.set_wp(1'b1);
    endtask : t_protect

    // program with buffer bit, read back, chain through sdo
    task automatic t_read();
        cmd(CMD_PROG_SLOT, 2'h1, 9'h1AA);
        wait_idle();
        cmd(CMD_LOAD_TAP, 2'h1, 9'h000);
        check("buffer and tap", 24'h1AA, {buf_en, tap});
        cmd(CMD_READ_TAP, 2'h0, 9'h000);
        host.xfer(24'h0ABCDE, 4, rx);
        check("read tap", word(CMD_READ_TAP, 2'h0, 9'h1AA), rx);
        host.xfer(word(CMD_READ_SLOT, 2'h1, 9'h000), 9, rx);
        check("chained", 24'h0ABCDE, rx);
        cmd(CMD_NOP, 2'h0, 9'h000);
        check("read slot", word(CMD_READ_SLOT, 2'h1, 9'h1AA), rx);
    endtask : t_read

    ////////////////////////////////////////////////////////////////////
    initial begin
        t_no_select();
        t_reset();
        t_write();
        t_step();
        t_store();
        t_protect();
        t_read();
        summarize();
    end

endmodule : digipot_serial_control_tb_top
